// file: shutdown_fade_sequencer.v
// Purpose: Shutdown, hold-off, fade-out and fade-in sequencing for five LED ports
// Assumes: Register strobes and acknowledge come from a serial slave in the clk_sys domain
// Notes: Pin and strobe inputs are synchronous to clk_sys
`timescale 1ns/100ps
`include "fade_seq_map.vh"

// Summary of operation
// - Shutdown turns constant-current ports off
// - Logic ports keep working during shutdown
// - Clearing run bit enters shutdown
// - Run bit set exits shutdown
// - Registers stay accessible, unchanged by shutdown
// - Port changed to current stays off
// - Port changed to logic drives at once
// - Hold full current, then fade down
// - One config write starts whole sequence
// - Status bits show hold, down, up
// - Config bit enables fade-in
// - Config read shows reset-run and ramps
// - Timing from PWM clock, oscillator kept
// - Three-bit DAC scales shared reference
// - Boost unscaled, off after fade-out
// - Global current sets fade knee
// - Fade-out field doubles from 0.0655s
// - Hold-off field doubles; top bits reserved
// - Fade-in field doubles; upper bits ignored
// - Reset edge plus quiet time restarts
// - Acknowledged access cancels reset-run
// - PWM clock nominal 31.25kHz
module shutdown_fade_sequencer #(
  parameter TICK_DIV = `SYS_CLK_HZ / `PWM_CLK_HZ, // System cycles per PWM period
  parameter PORTS = 5 // Number of LED ports
) (
  input wire clk_sys,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  input wire bus_ack,
  input wire rst_pin,
  input wire [8*PORTS-1:0] port_setting,
  input wire [PORTS-1:0] pwm_on,
  input wire [2:0] glob_cur,
  input wire pwm_demand,
  output reg [PORTS-1:0] port_sink_r,
  output reg [2:0] ref_level_r,
  output reg boost_en_r,
  output reg osc_en_r
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [4:0] S_RUN = 5'h01; // Normal operation
  localparam [4:0] S_HOLD = 5'h02; // Hold-off at full current
  localparam [4:0] S_DOWN = 5'h04; // Fading out
  localparam [4:0] S_OFF = 5'h08; // Shut down
  localparam [4:0] S_UP = 5'h10; // Fading in

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Port setting lies in the constant-current range
  function is_cc;
    input [7:0] v;
    begin
      is_cc = (v != `PORT_LOGIC_LOW) && (v != `PORT_LOGIC_HIGH) && (v != `PORT_HIGH_Z);
    end
  endfunction

  // Span of a nonzero timing code in PWM periods
  function [17:0] span_ticks;
    input [2:0] code;
    reg [31:0] base;
    begin
      base = `FADE_BASE_TICKS;
      span_ticks = base[17:0] << (code - 3'h1);
    end
  endfunction

  // Lower of two levels
  function [2:0] lower;
    input [2:0] a;
    input [2:0] b;
    begin
      lower = (a < b) ? a : b;
    end
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg rst_meta_r; // First release stage
  reg rst_n; // Released reset for the design

  // Release reset through two flops
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // PWM clock
  // ----------------------------------------------------------------
  wire tick; // One pulse per PWM period

  // Divider to the 31.25 kHz PWM clock
  pwm_tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick_r(tick)
  );

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg [7:0] cfg_r; // Stored configuration bits
  reg [5:0] fade_out_r; // Hold-off and fade-out codes
  reg [2:0] fade_in_r; // Fade-in code
  reg [4:0] state_r; // Sequencer state
  reg [4:0] state_nxt;
  reg [17:0] cnt_r; // PWM periods within interval
  reg [17:0] cnt_nxt;
  reg [2:0] step_r; // Fade DAC step
  reg [2:0] step_nxt;
  reg rst_pin_r; // Reset pin last cycle
  reg rr_wait_r; // Reset-run timeout armed
  reg [7:0] rr_cnt_r; // Reset-run quiet periods
  wire wr_cfg; // Write to configuration
  wire [2:0] down_code; // Fade-out code
  wire [2:0] hold_code; // Hold-off code
  wire [17:0] interval; // PWM periods per DAC step
  wire [17:0] hold_span; // Hold-off length
  wire rr_fire; // Reset-run timeout reached
  wire rr_cancel; // Reset-run cancelled by access
  wire [7:0] cfg_view; // Configuration as read
  assign wr_cfg = reg_wr && (reg_addr == `ADDR_CORE_CFG);
  assign down_code = fade_out_r[`DOWN_MSB:`DOWN_LSB];
  assign hold_code = fade_out_r[`HOLD_MSB:`HOLD_LSB];
  assign hold_span = span_ticks(hold_code);
  assign rr_cancel = rr_wait_r && bus_ack;
  assign rr_fire = rr_wait_r && !bus_ack && tick && (rr_cnt_r == `RR_TIMEOUT_TICKS - 8'h01);

  // Step interval for the active fade direction
  assign interval = (state_r == S_UP) ? (span_ticks(fade_in_r) >> 3) :
                    (span_ticks(down_code) >> 3);

  // Status bits merged over stored bits
  assign cfg_view = {cfg_r[`CFG_STAGGER], cfg_r[`CFG_RST_CLR], cfg_r[`CFG_UP_EN],
                     state_r == S_UP, state_r == S_DOWN, state_r == S_HOLD,
                     cfg_r[`CFG_RR_EN], cfg_r[`CFG_RUN]};

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Writes at any time; run bit set by reset-run wins
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `CFG_RESET;
      fade_out_r <= `FADE_OUT_RESET;
      fade_in_r <= `FADE_IN_RESET;
    end else begin
      // Configuration, status bits are never stored
      if (wr_cfg) begin
        cfg_r <= reg_wdata & `CFG_WR_MASK;
      end
      // Cancel clears reset-run enable
      if (rr_cancel) begin
        cfg_r[`CFG_RR_EN] <= 1'b0;
      end
      // Timeout sets the run bit
      if (rr_fire) begin
        cfg_r[`CFG_RUN] <= 1'b1;
      end
      // Fade-out and hold-off, reserved bits dropped
      if (reg_wr && (reg_addr == `ADDR_FADE_OUT)) begin
        fade_out_r <= reg_wdata[`HOLD_MSB:`DOWN_LSB];
      end
      // Fade-in, upper bits ignored
      if (reg_wr && (reg_addr == `ADDR_FADE_IN)) begin
        fade_in_r <= reg_wdata[`UP_MSB:`UP_LSB];
      end
    end
  end

  // Read data, unmapped reads return zero
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_CORE_CFG: reg_rdata_r <= cfg_view;
        `ADDR_FADE_OUT: reg_rdata_r <= {2'h0, fade_out_r};
        `ADDR_FADE_IN: reg_rdata_r <= {5'h00, fade_in_r};
        default: reg_rdata_r <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Reset-run trigger
  // ----------------------------------------------------------------
  // Arm on a rising pin edge while enabled and shut down
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pin_r <= 1'b0;
      rr_wait_r <= 1'b0;
      rr_cnt_r <= 8'h00;
    end else begin
      rst_pin_r <= rst_pin;
      if (rr_cancel || rr_fire || !rst_pin || !cfg_r[`CFG_RR_EN] || cfg_r[`CFG_RUN]) begin
        // Short pulses and finished triggers disarm
        rr_wait_r <= 1'b0;
        rr_cnt_r <= 8'h00;
      end else if (rst_pin && !rst_pin_r) begin
        rr_wait_r <= 1'b1;
        rr_cnt_r <= 8'h00;
      end else if (rr_wait_r && tick) begin
        rr_cnt_r <= rr_cnt_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state from run bit level and interval counts
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    step_nxt = step_r;
    case (state_r)
      S_RUN: begin
        // Run cleared starts hold-off, fade-out or stop
        if (!cfg_r[`CFG_RUN]) begin
          cnt_nxt = 18'h00000;
          step_nxt = 3'h7;
          if (hold_code != 3'h0) begin
            state_nxt = S_HOLD;
          end else if (down_code != 3'h0) begin
            state_nxt = S_DOWN;
          end else begin
            state_nxt = S_OFF;
          end
        end
      end
      S_HOLD: begin
        // Full current until hold-off span ends
        if (cfg_r[`CFG_RUN]) begin
          state_nxt = S_RUN;
        end else if (tick) begin
          if (cnt_r + 18'h00001 >= hold_span) begin
            cnt_nxt = 18'h00000;
            state_nxt = (down_code != 3'h0) ? S_DOWN : S_OFF;
          end else begin
            cnt_nxt = cnt_r + 18'h00001;
          end
        end
      end
      S_DOWN: begin
        // One DAC step down per interval
        if (cfg_r[`CFG_RUN]) begin
          state_nxt = S_RUN;
        end else if (tick) begin
          if (cnt_r + 18'h00001 >= interval) begin
            cnt_nxt = 18'h00000;
            if (step_r == 3'h0) begin
              state_nxt = S_OFF;
            end else begin
              step_nxt = step_r - 3'h1;
            end
          end else begin
            cnt_nxt = cnt_r + 18'h00001;
          end
        end
      end
      S_OFF: begin
        // Run set leaves shutdown, with fade-in if enabled
        if (cfg_r[`CFG_RUN]) begin
          cnt_nxt = 18'h00000;
          step_nxt = 3'h0;
          if (cfg_r[`CFG_UP_EN] && (fade_in_r != 3'h0)) begin
            state_nxt = S_UP;
          end else begin
            state_nxt = S_RUN;
          end
        end
      end
      S_UP: begin
        // One DAC step up per interval
        if (!cfg_r[`CFG_RUN]) begin
          state_nxt = S_RUN;
        end else if (tick) begin
          if (cnt_r + 18'h00001 >= interval) begin
            cnt_nxt = 18'h00000;
            if (step_r == 3'h7) begin
              state_nxt = S_RUN;
            end else begin
              step_nxt = step_r + 3'h1;
            end
          end else begin
            cnt_nxt = cnt_r + 18'h00001;
          end
        end
      end
      default: begin
        state_nxt = S_OFF;
      end
    endcase
  end

  // State registers, reset starts in shutdown
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= S_OFF;
      cnt_r <= 18'h00000;
      step_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      step_r <= step_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Port sinks, reference, boost and oscillator request
  integer i;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port_sink_r <= {PORTS{1'b0}};
      ref_level_r <= 3'h0;
      boost_en_r <= 1'b0;
      osc_en_r <= 1'b0;
    end else begin
      for (i = 0; i < PORTS; i = i + 1) begin
        if (is_cc(port_setting[8*i +: 8])) begin
          // Current ports off and high impedance in shutdown
          port_sink_r[i] <= (state_nxt != S_OFF) && pwm_on[i];
        end else begin
          // Logic ports follow their setting at once
          port_sink_r[i] <= (port_setting[8*i +: 8] == `PORT_LOGIC_LOW);
        end
      end
      // Fade step clipped by the global current knee
      if ((state_nxt == S_RUN) || (state_nxt == S_HOLD)) begin
        ref_level_r <= glob_cur;
      end else begin
        ref_level_r <= lower(step_nxt, glob_cur);
      end
      boost_en_r <= (state_nxt != S_OFF);
      osc_en_r <= pwm_demand || ((state_nxt != S_RUN) && (state_nxt != S_OFF));
    end
  end

endmodule // shutdown_fade_sequencer

// file: fade_seq_map.vh
// Purpose: Register map, field positions and timing constants of the shutdown fade sequencer
// Assumes: Included by the sequencer and its tick divider
// Notes: Definitions only
`ifndef FADE_SEQ_MAP_VH
`define FADE_SEQ_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_CORE_CFG 8'h10
`define ADDR_FADE_OUT 8'h11
`define ADDR_FADE_IN 8'h12

// ----------------------------------------------------------------
// Core configuration fields
// ----------------------------------------------------------------
`define CFG_RUN 0
`define CFG_RR_EN 1
`define CFG_ST_HOLD 2
`define CFG_ST_DOWN 3
`define CFG_ST_UP 4
`define CFG_UP_EN 5
`define CFG_RST_CLR 6
`define CFG_STAGGER 7
`define CFG_RESET 8'h00
// Bits software may write
`define CFG_WR_MASK 8'he3

// ----------------------------------------------------------------
// Timing fields
// ----------------------------------------------------------------
`define DOWN_LSB 0
`define DOWN_MSB 2
`define HOLD_LSB 3
`define HOLD_MSB 5
`define UP_LSB 0
`define UP_MSB 2
`define FADE_OUT_RESET 6'h00
`define FADE_IN_RESET 3'h0

// ----------------------------------------------------------------
// Port setting codes
// ----------------------------------------------------------------
`define PORT_LOGIC_LOW 8'h00
`define PORT_LOGIC_HIGH 8'h01
`define PORT_HIGH_Z 8'hff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SYS_CLK_HZ 250000000
`define PWM_CLK_HZ 31250
// Shortest fade span, in microseconds (0.0655 s)
`define FADE_BASE_US 65500
// Fade span in PWM periods, rounded down
`define FADE_BASE_TICKS ((`FADE_BASE_US * `PWM_CLK_HZ) / 1000000)
// Number of fade levels
`define FADE_LEVELS 8
// Reset-run quiet time in PWM periods
`define RR_TIMEOUT_TICKS 8'h80

`endif

// file: pwm_tick_gen.v
// Purpose: Divides the system clock down to the PWM clock and emits one pulse per PWM period
// Assumes: clk_sys at 250 MHz, asynchronous active-low reset already released cleanly
// Notes: The divider keeps running so fade timing never stalls
`timescale 1ns/100ps
`include "fade_seq_map.vh"

module pwm_tick_gen #(
  parameter DIV = `SYS_CLK_HZ / `PWM_CLK_HZ // System cycles per PWM period
) (
  input wire clk_sys,
  input wire rst_n,
  output reg tick_r
);

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  reg [15:0] div_r; // Cycle count within a period

  // Count to DIV-1 then wrap with a tick
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (div_r == DIV[15:0] - 16'h0001) begin
      div_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

endmodule // pwm_tick_gen

// file: sfs_checker.sv
// Purpose: Port assertions for the shutdown fade sequencer
// Assumes: One clock domain, rst_b active low
// Notes: Spacing check needs TICK_DIV of 4 or more
`timescale 1ns/100ps
module sfs_checker #(
  parameter TICK_DIV = 4,
  parameter PORTS = 5
) (
  input wire clk_sys,
  input wire rst_b,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_r,
  input wire bus_ack,
  input wire rst_pin,
  input wire [8*PORTS-1:0] port_setting,
  input wire [PORTS-1:0] pwm_on,
  input wire [2:0] glob_cur,
  input wire pwm_demand,
  input wire [PORTS-1:0] port_sink_r,
  input wire [2:0] ref_level_r,
  input wire boost_en_r,
  input wire osc_en_r
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_logic_low_on: assert property ((port_setting[7:0] == 8'h00) [*5] |-> port_sink_r[0])
    else $error("logic low port not sinking");
  a_logic_high_off: assert property ((port_setting[15:8] == 8'h01) [*5] |-> !port_sink_r[1])
    else $error("logic high port sinking");
  a_cc_off_sd: assert property ((port_setting[23:16] inside {[8'h02:8'hfe]} && !boost_en_r) [*2]
    |-> !port_sink_r[2])
    else $error("current port on in shutdown");
  a_ref_step_spaced: assert property ($changed(ref_level_r) && boost_en_r && $past(boost_en_r)
    && $stable(glob_cur) |=> $stable(ref_level_r) [*3])
    else $error("fade steps too close");
  a_osc_in_fade: assert property (ref_level_r < $past(ref_level_r) && boost_en_r
    && $stable(glob_cur) |-> osc_en_r)
    else $error("oscillator off during fade");
  a_ref_under_knee: assert property (ref_level_r <= $past(glob_cur))
    else $error("fade level above global current");
  a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata_r))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (reg_rd && !(reg_addr inside {[8'h10:8'h12]})
    |=> reg_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  a_out_rsvd_zero: assert property (reg_rd && reg_addr == 8'h11 |=> reg_rdata_r[7:6] == 2'h0)
    else $error("fade-out reserved bits set");
  a_in_upper_zero: assert property (reg_rd && reg_addr == 8'h12 |=> reg_rdata_r[7:3] == 5'h00)
    else $error("fade-in upper bits set");
  a_status_idle: assert property (reg_rd && reg_addr == 8'h10 && !boost_en_r && !$past(boost_en_r)
    |=> reg_rdata_r[4:2] == 3'h0)
    else $error("status bits set while off");
  // Main scenarios seen
  c_fade_end: cover property ($fell(boost_en_r));
  c_start: cover property ($rose(boost_en_r));
  c_step: cover property (ref_level_r < $past(ref_level_r) && boost_en_r);
endmodule // sfs_checker

bind shutdown_fade_sequencer sfs_checker #(.TICK_DIV(TICK_DIV), .PORTS(PORTS)) sfs_checker_i (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .bus_ack(bus_ack), .rst_pin(rst_pin),
  .port_setting(port_setting), .pwm_on(pwm_on), .glob_cur(glob_cur), .pwm_demand(pwm_demand),
  .port_sink_r(port_sink_r), .ref_level_r(ref_level_r), .boost_en_r(boost_en_r), .osc_en_r(osc_en_r));

// file: fade_bus_master.sv
// Purpose: Register bus master standing in for the serial front end
// Assumes: Read data lands on the strobe edge
// Notes: Every transfer is acknowledged, as an addressed access would be
`timescale 1ns/100ps
module fade_bus_master (
  input wire clk_sys,
  input wire [7:0] reg_rdata_r,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic bus_ack
);
  // ----------------------------------------
  // Idle bus
  // ----------------------------------------
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    bus_ack = 1'b0;
  end
  // One write; released lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    bus_ack = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    bus_ack = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // One read, acknowledged like any access
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    bus_ack = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    bus_ack = 1'b0;
    reg_addr = ~a;
    q = reg_rdata_r;
  endtask
endmodule // fade_bus_master

// file: tb_shutdown_fade_sequencer.sv
// Purpose: Self-checking bench for the shutdown fade sequencer
// Assumes: TICK_DIV of 4 keeps fades short
// Notes: Inputs move on the falling edge
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL %s expected %h seen %h", n, e, g); end end
module tb_shutdown_fade_sequencer;
  localparam TD = 4; // Cycles per PWM tick
  localparam SPAN = 2046 * TD; // Code 1 span in cycles
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic rst_pin = 1'b0;
  logic [39:0] port_setting = 40'h02fe800100; // Ports 4..0
  logic [4:0] pwm_on = 5'h1f;
  logic [2:0] glob_cur = 3'h7;
  logic pwm_demand = 1'b0;
  logic reg_wr, reg_rd, bus_ack, boost_en_r, osc_en_r;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r, q;
  logic [4:0] port_sink_r;
  logic [2:0] ref_level_r;
  int n_mismatch = 0;
  int num_checks = 0;
  int t0 = 0;
  int cyc = 0;
  // Address, write data, read back
  logic [23:0] rows [4] = '{24'h11c909, 24'h12f901, 24'h103c20, 24'h135500};
  // ----------------------------------------
  // Clock, design and bus master
  // ----------------------------------------
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  shutdown_fade_sequencer #(.TICK_DIV(TD)) shutdown_fade_sequencer_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
    .bus_ack(bus_ack), .rst_pin(rst_pin), .port_setting(port_setting), .pwm_on(pwm_on), .glob_cur(glob_cur),
    .pwm_demand(pwm_demand), .port_sink_r(port_sink_r), .ref_level_r(ref_level_r), .boost_en_r(boost_en_r),
    .osc_en_r(osc_en_r));
  fade_bus_master fade_bus_master_i (.clk_sys(clk_sys), .reg_rdata_r(reg_rdata_r), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .bus_ack(bus_ack));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    fade_bus_master_i.rd(a, q);
    `CHK("read", e, q)
  endtask
  task automatic at(input int c);
    while (cyc < c) @(negedge clk_sys);
  endtask
  // Bounded wait for boost level, counted from t0
  task automatic wait_boost(input logic lv, input int lim);
    while (boost_en_r !== lv) begin
      @(negedge clk_sys);
      if (cyc - t0 > lim) begin
        n_mismatch++;
        finish_test();
      end
    end
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    `CHK("sink", 5'h01, port_sink_r)
    for (int i = 0; i < 3; i++) rchk(8'h10 + 8'(i), 8'h00);
    foreach (rows[i]) begin
      fade_bus_master_i.wr(rows[i][23:16], rows[i][15:8]);
      rchk(rows[i][23:16], rows[i][7:0]);
    end
    fade_bus_master_i.wr(8'h10, 8'h21);
    t0 = cyc;
    repeat (20) @(negedge clk_sys);
    `CHK("boost", 1'b1, boost_en_r)
    rchk(8'h10, 8'h31);
    at(t0 + SPAN - 40);
    rchk(8'h10, 8'h31);
    at(t0 + SPAN + 40);
    rchk(8'h10, 8'h21);
    `CHK("ref", 3'h7, ref_level_r)
    `CHK("sink", 5'h1d, port_sink_r)
    fade_bus_master_i.wr(8'h10, 8'h20);
    t0 = cyc;
    repeat (20) @(negedge clk_sys);
    rchk(8'h10, 8'h24);
    `CHK("osc", 1'b1, osc_en_r)
    `CHK("sink", 5'h1d, port_sink_r)
    at(t0 + SPAN + 40);
    rchk(8'h10, 8'h28);
    `CHK("boost", 1'b1, boost_en_r)
    glob_cur = 3'h3;
    repeat (2) @(negedge clk_sys);
    `CHK("knee", 3'h3, ref_level_r)
    glob_cur = 3'h7;
    wait_boost(1'b0, 3 * SPAN);
    `CHK("span", 1'b1, (cyc - t0) inside {[4082 * TD:4092 * TD]})
    `CHK("sink", 5'h01, port_sink_r)
    rchk(8'h11, 8'h09);
    port_setting[15:8] = 8'h80;
    port_setting[23:16] = 8'h00;
    repeat (3) @(negedge clk_sys);
    `CHK("sink", 5'h05, port_sink_r)
    fade_bus_master_i.wr(8'h12, 8'h00);
    fade_bus_master_i.wr(8'h10, 8'h21);
    repeat (10) @(negedge clk_sys);
    `CHK("sink", 5'h1f, port_sink_r)
    rchk(8'h10, 8'h21);
    port_setting = 40'h02fe800100;
    fade_bus_master_i.wr(8'h11, 8'h00);
    fade_bus_master_i.wr(8'h12, 8'h01);
    fade_bus_master_i.wr(8'h10, 8'h22);
    repeat (10) @(negedge clk_sys);
    `CHK("boost", 1'b0, boost_en_r)
    `CHK("osc", 1'b0, osc_en_r)
    pwm_demand = 1'b1;
    @(negedge clk_sys);
    `CHK("osc", 1'b1, osc_en_r)
    pwm_demand = 1'b0;
    rst_pin = 1'b1;
    t0 = cyc;
    wait_boost(1'b1, 1000);
    `CHK("delay", 1'b1, (cyc - t0) inside {[127 * TD:130 * TD]})
    fade_bus_master_i.rd(8'h10, q);
    `CHK("run", 2'h3, {q[4], q[0]})
    rst_pin = 1'b0;
    fade_bus_master_i.wr(8'h10, 8'h22);
    repeat (10) @(negedge clk_sys);
    rst_pin = 1'b1;
    repeat (100) @(negedge clk_sys);
    fade_bus_master_i.rd(8'h10, q);
    repeat (700) @(negedge clk_sys);
    rchk(8'h10, 8'h20);
    `CHK("boost", 1'b0, boost_en_r)
    rst_b = 1'b0;
    #1;
    `CHK("reset", 9'h000, {port_sink_r, ref_level_r, boost_en_r})
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    rchk(8'h11, 8'h00);
    rchk(8'h12, 8'h00);
    finish_test();
  end
endmodule // tb_shutdown_fade_sequencer
